/* rtl/bvl_top.sv */
// register bank and control of the battery-voltage gain limiter
//
// Summary of operation
// - An 8-bit knee level is held; at or below it the audio limiter is muted or engaged, by mode.
// - The 2-bit release code selects 3200, 1600, 1200 or 800 ms per dB of release.
// - The 2-bit attack code selects 120, 60, 30 or 20 us per dB of attack.
// - With the enable bit set the battery cut starts once the battery code reaches the trip level; cleared it cuts nothing.
// - Cut depth is capped at 0.75 dB times the 4-bit code plus one.
// - Hold-off code 0 is none, 1 to 10 are 200 ms steps, 11 to 15 are 2500, 3000, 4000, 5000 and 6000 ms.
// - Four tie bits at 0 to 3 each link limiter gain to automatic gain input 1 to 4.
// - The rates byte resets to A0: 1200 ms/dB release, 30 us/dB attack, cut off.
// - The depth and hold-off byte resets to 65: 5.25 dB cap and 1000 ms hold-off.
// - A level code means 4 + 14*code/255 volts, so knee and trip compare directly in codes.
// - Mode 10 mutes while below the knee; mode 11 engages the limiter only while below it.
// - Status bit 5 reads 1 while any limiter or gain cut is reducing gain.
`include "bvl_consts.svh"

module bvl_top #(
   parameter int unsigned CYC_PER_US = `BVL_CLK_MHZ,
   parameter int unsigned US_PER_MS = `BVL_US_PER_MS
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [7:0] regRdData,
   output logic regRdValid,
   input wire logic [7:0] batteryLevel,
   input wire logic [1:0] peakCutMode,
   input wire logic peakCutReducing,
   output logic kneeReached,
   output logic muteRequest,
   output logic peakCutEngage,
   output logic [4:0] battCutDepth,
   output logic [3:0] peakCutTies,
   output logic [7:0] clipPoint,
   output logic gainCutActive
);
   // ****************************************
   // elaboration checks
   // ****************************************
   // the longest release and hold-off counts must still fit the 32-bit timers
   if (CYC_PER_US < 1 || CYC_PER_US > 1000 || US_PER_MS < 1 || US_PER_MS > 1000 ||
      CYC_PER_US * US_PER_MS > 100000) begin : gChk
      $error("bvl_top: timing scale out of range");
   end

   // ****************************************
   // register storage
   // ****************************************
   logic [7:0] knee_reg;
   logic [7:0] rates_reg;
   logic [7:0] trip_reg;
   logic [7:0] cutHold_reg;
   logic [7:0] ties_reg;
   logic [7:0] clip_reg;
   logic [7:0] rdData_next;

   // software writes, reserved bits masked off
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rates_reg <= `BVL_RST_RATES;
         cutHold_reg <= `BVL_RST_CUTHOLD;
         knee_reg <= `BVL_RST_KNEE;
         trip_reg <= `BVL_RST_TRIP;
         ties_reg <= `BVL_RST_TIES;
         clip_reg <= `BVL_RST_CLIP;
      end else if (regWrEn) begin
         unique case (regAddr)
            `BVL_OFS_KNEE: knee_reg <= regWrData;
            `BVL_OFS_RATES: rates_reg <= regWrData & `BVL_RATES_MASK;
            `BVL_OFS_TRIP: trip_reg <= regWrData;
            `BVL_OFS_CUTHOLD: cutHold_reg <= regWrData;
            `BVL_OFS_TIES: ties_reg <= regWrData & `BVL_TIES_MASK;
            `BVL_OFS_CLIP: clip_reg <= regWrData;
            default: begin
            end
         endcase
      end
   end

   // read multiplexer, unmapped offsets read zero
   always_comb begin
      rdData_next = 8'h00;
      unique case (regAddr)
         `BVL_OFS_KNEE: rdData_next = knee_reg;
         `BVL_OFS_RATES: rdData_next = rates_reg;
         `BVL_OFS_TRIP: rdData_next = trip_reg;
         `BVL_OFS_CUTHOLD: rdData_next = cutHold_reg;
         `BVL_OFS_TIES: rdData_next = ties_reg;
         `BVL_OFS_CLIP: rdData_next = clip_reg;
         `BVL_OFS_STATUS: rdData_next[`BVL_STATUS_GAINCUT_BIT] = gainCutActive;
         default: rdData_next = 8'h00;
      endcase
   end

   // registered read answer, one cycle after the strobe
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         regRdData <= 8'h00;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRdEn;
         if (regRdEn) begin
            regRdData <= rdData_next;
         end
      end
   end

   // ****************************************
   // timing selection
   // ****************************************
   logic [31:0] atkUs;
   logic [31:0] relMs;
   logic [31:0] holdMs;
   logic [3:0] holdCode;

   assign holdCode = cutHold_reg[3:0];

   // per-dB attack and release figures from the rate codes
   always_comb begin
      atkUs = 32'(`BVL_ATK_US_2);
      relMs = 32'(`BVL_REL_MS_2);
      unique case (rates_reg[5:4])
         2'h0: atkUs = 32'(`BVL_ATK_US_0);
         2'h1: atkUs = 32'(`BVL_ATK_US_1);
         2'h2: atkUs = 32'(`BVL_ATK_US_2);
         2'h3: atkUs = 32'(`BVL_ATK_US_3);
      endcase
      unique case (rates_reg[7:6])
         2'h0: relMs = 32'(`BVL_REL_MS_0);
         2'h1: relMs = 32'(`BVL_REL_MS_1);
         2'h2: relMs = 32'(`BVL_REL_MS_2);
         2'h3: relMs = 32'(`BVL_REL_MS_3);
      endcase
   end

   // hold-off figure from its code
   always_comb begin
      holdMs = 32'(holdCode) * 32'(`BVL_HOLD_STEP_MS);
      unique case (holdCode)
         4'hB: holdMs = 32'(`BVL_HOLD_MS_11);
         4'hC: holdMs = 32'(`BVL_HOLD_MS_12);
         4'hD: holdMs = 32'(`BVL_HOLD_MS_13);
         4'hE: holdMs = 32'(`BVL_HOLD_MS_14);
         4'hF: holdMs = 32'(`BVL_HOLD_MS_15);
         default: holdMs = 32'(holdCode) * 32'(`BVL_HOLD_STEP_MS);
      endcase
   end

   // ****************************************
   // attenuation ramp
   // ****************************************
   bvl_ramp_if rampIf ();

   assign rampIf.cutOn = rates_reg[0];
   assign rampIf.tripped = (batteryLevel <= trip_reg);
   assign rampIf.maxSteps = {1'b0, cutHold_reg[7:4]} + 5'h01;
   assign rampIf.attackCycles = atkUs * 32'(CYC_PER_US) * 32'(`BVL_STEP_NUM)
      / 32'(`BVL_STEP_DEN);
   assign rampIf.releaseCycles = relMs * 32'(US_PER_MS) * 32'(CYC_PER_US)
      * 32'(`BVL_STEP_NUM) / 32'(`BVL_STEP_DEN);
   assign rampIf.holdCycles = holdMs * 32'(US_PER_MS) * 32'(CYC_PER_US);

   bvl_ramp uRamp (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .rampIf(rampIf)
   );

   // ****************************************
   // audio limiter mode control and outputs
   // ****************************************
   logic belowKnee;

   assign belowKnee = (batteryLevel <= knee_reg);

   // knee, mute and engage requests by mode
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         kneeReached <= 1'b0;
         muteRequest <= 1'b0;
         peakCutEngage <= 1'b0;
      end else begin
         kneeReached <= belowKnee;
         muteRequest <= (bvl_pkg::bvl_mode_t'(peakCutMode) == bvl_pkg::MODE_MUTE) && belowKnee;
         unique case (bvl_pkg::bvl_mode_t'(peakCutMode))
            bvl_pkg::MODE_OFF: peakCutEngage <= 1'b0;
            bvl_pkg::MODE_ON: peakCutEngage <= 1'b1;
            bvl_pkg::MODE_MUTE: peakCutEngage <= 1'b0;
            bvl_pkg::MODE_BELOW: peakCutEngage <= belowKnee;
         endcase
      end
   end

   // depth, ties, clip and status outputs
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         battCutDepth <= 5'h00;
         peakCutTies <= 4'h0;
         clipPoint <= `BVL_RST_CLIP;
         gainCutActive <= 1'b0;
      end else begin
         battCutDepth <= rampIf.depth;
         peakCutTies <= ties_reg[3:0];
         clipPoint <= clip_reg;
         gainCutActive <= (rampIf.depth != 5'h00) || peakCutReducing;
      end
   end
endmodule : bvl_top

/* rtl/bvl_consts.svh */
// offsets, field positions, reset values and timing figures of the battery limiter bank
`ifndef BVL_CONSTS_SVH
`define BVL_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define BVL_OFS_KNEE 8'h0A
`define BVL_OFS_RATES 8'h0B
`define BVL_OFS_TRIP 8'h0C
`define BVL_OFS_CUTHOLD 8'h0D
`define BVL_OFS_TIES 8'h0E
`define BVL_OFS_CLIP 8'h0F
`define BVL_OFS_STATUS 8'h11

// ****************************************
// reset values
// ****************************************
`define BVL_RST_KNEE 8'h22
`define BVL_RST_RATES 8'hA0
`define BVL_RST_TRIP 8'h22
`define BVL_RST_CUTHOLD 8'h65
`define BVL_RST_TIES 8'h00
`define BVL_RST_CLIP 8'hFF

// ****************************************
// field positions and writable masks
// ****************************************
`define BVL_RATES_MASK 8'hF1
`define BVL_TIES_MASK 8'h0F
`define BVL_STATUS_GAINCUT_BIT 5

// ****************************************
// timing figures
// ****************************************
`define BVL_CLK_MHZ 50
`define BVL_US_PER_MS 1000
`define BVL_ATK_US_0 120
`define BVL_ATK_US_1 60
`define BVL_ATK_US_2 30
`define BVL_ATK_US_3 20
`define BVL_REL_MS_0 3200
`define BVL_REL_MS_1 1600
`define BVL_REL_MS_2 1200
`define BVL_REL_MS_3 800
`define BVL_HOLD_STEP_MS 200
`define BVL_HOLD_MS_11 2500
`define BVL_HOLD_MS_12 3000
`define BVL_HOLD_MS_13 4000
`define BVL_HOLD_MS_14 5000
`define BVL_HOLD_MS_15 6000
// one attenuation step is 0.75 dB, so a per-dB time scales by 3/4
`define BVL_STEP_NUM 3
`define BVL_STEP_DEN 4

`endif

/* rtl/bvl_pkg.sv */
// types shared by the battery limiter bank
package bvl_pkg;
   typedef enum logic [1:0] {
      CUT_IDLE,
      CUT_ATTACK,
      CUT_HOLD,
      CUT_RELEASE
   } bvl_state_t;

   typedef enum logic [1:0] {
      MODE_OFF,
      MODE_ON,
      MODE_MUTE,
      MODE_BELOW
   } bvl_mode_t;
endpackage : bvl_pkg

/* rtl/bvl_ramp_if.sv */
// carrier between the register bank and the attenuation ramp
interface bvl_ramp_if;
   logic cutOn;
   logic tripped;
   logic [4:0] maxSteps;
   logic [31:0] attackCycles;
   logic [31:0] releaseCycles;
   logic [31:0] holdCycles;
   logic [4:0] depth;

   modport ctrl (output cutOn, tripped, maxSteps, attackCycles, releaseCycles, holdCycles,
      input depth);
   modport ramp (input cutOn, tripped, maxSteps, attackCycles, releaseCycles, holdCycles,
      output depth);
endinterface : bvl_ramp_if

/* rtl/bvl_ramp.sv */
// attenuation ramp of the battery limiter: attack, hold-off and release
module bvl_ramp (
   input wire logic clk_sys,
   input wire logic resetn,
   bvl_ramp_if.ramp rampIf
);
   bvl_pkg::bvl_state_t state_reg;
   logic [31:0] timer_reg;
   logic [4:0] depth_reg;
   logic timerDone;

   assign rampIf.depth = depth_reg;

   // timer has reached the period selected by the current state
   always_comb begin
      timerDone = 1'b0;
      unique case (state_reg)
         bvl_pkg::CUT_ATTACK: timerDone = (timer_reg + 32'h1 >= rampIf.attackCycles);
         bvl_pkg::CUT_HOLD: timerDone = (timer_reg + 32'h1 >= rampIf.holdCycles);
         bvl_pkg::CUT_RELEASE: timerDone = (timer_reg + 32'h1 >= rampIf.releaseCycles);
         bvl_pkg::CUT_IDLE: timerDone = 1'b0;
      endcase
   end

   // step machine, one 0.75 dB step per period
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_reg <= bvl_pkg::CUT_IDLE;
         timer_reg <= 32'h0;
         depth_reg <= 5'h00;
      end else if (!rampIf.cutOn) begin
         state_reg <= bvl_pkg::CUT_IDLE;
         timer_reg <= 32'h0;
         depth_reg <= 5'h00;
      end else if (rampIf.tripped) begin
         if (state_reg != bvl_pkg::CUT_ATTACK) begin
            state_reg <= bvl_pkg::CUT_ATTACK;
            timer_reg <= 32'h0;
         end else if (timerDone) begin
            timer_reg <= 32'h0;
            if (depth_reg < rampIf.maxSteps) begin
               depth_reg <= depth_reg + 5'h01;
            end
         end else begin
            timer_reg <= timer_reg + 32'h1;
         end
         if (depth_reg > rampIf.maxSteps) begin
            depth_reg <= rampIf.maxSteps;
         end
      end else begin
         unique case (state_reg)
            bvl_pkg::CUT_IDLE: begin
               timer_reg <= 32'h0;
            end
            bvl_pkg::CUT_ATTACK: begin
               timer_reg <= 32'h0;
               if (depth_reg == 5'h00) begin
                  state_reg <= bvl_pkg::CUT_IDLE;
               end else if (rampIf.holdCycles == 32'h0) begin
                  state_reg <= bvl_pkg::CUT_RELEASE;
               end else begin
                  state_reg <= bvl_pkg::CUT_HOLD;
               end
            end
            bvl_pkg::CUT_HOLD: begin
               if (timerDone) begin
                  state_reg <= bvl_pkg::CUT_RELEASE;
                  timer_reg <= 32'h0;
               end else begin
                  timer_reg <= timer_reg + 32'h1;
               end
            end
            bvl_pkg::CUT_RELEASE: begin
               if (depth_reg == 5'h00) begin
                  state_reg <= bvl_pkg::CUT_IDLE;
                  timer_reg <= 32'h0;
               end else if (timerDone) begin
                  timer_reg <= 32'h0;
                  depth_reg <= depth_reg - 5'h01;
               end else begin
                  timer_reg <= timer_reg + 32'h1;
               end
            end
         endcase
      end
   end
endmodule : bvl_ramp

/* test/bvl_top_monitor.sv */
// port-level assertions for the battery limiter bank
module bvl_top_monitor #(
   parameter int unsigned CYC_PER_US = 50,
   parameter int unsigned US_PER_MS = 1000
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid,
   input wire logic [7:0] batteryLevel,
   input wire logic [1:0] peakCutMode,
   input wire logic peakCutReducing,
   input wire logic kneeReached,
   input wire logic muteRequest,
   input wire logic peakCutEngage,
   input wire logic [4:0] battCutDepth,
   input wire logic [3:0] peakCutTies,
   input wire logic [7:0] clipPoint,
   input wire logic gainCutActive
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // assertions, all on the system clock
   // ****************************************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   a_rates_reserved: assert property (
      regRdValid && $past(regAddr) == 8'h0B |-> regRdData[3:1] == 3'h0)
      else $error("rates byte reserved bits not zero");
   a_ties_reserved: assert property (
      regRdValid && $past(regAddr) == 8'h0E |-> regRdData[7:4] == 4'h0)
      else $error("tie byte reserved bits not zero");
   a_status_byte: assert property (
      regRdValid && $past(regAddr) == 8'h11 |-> (regRdData & 8'hDF) == 8'h00)
      else $error("status byte has bits other than gain cut");
   a_gain_flag: assert property (
      gainCutActive == (battCutDepth != 5'h00 || $past(peakCutReducing)))
      else $error("gain cut flag does not follow its causes");
   a_depth_step: assert property (
      battCutDepth > $past(battCutDepth) |-> battCutDepth == $past(battCutDepth) + 5'h01)
      else $error("cut depth rose by more than one step");
   a_depth_cap: assert property (battCutDepth <= 5'h10)
      else $error("cut depth beyond sixteen steps");
   a_mute_mode: assert property (
      muteRequest == (kneeReached && $past(peakCutMode) == 2'h2))
      else $error("mute request wrong for mode and knee");
   a_engage_mode: assert property (
      peakCutEngage == ($past(peakCutMode) == 2'h1 || ($past(peakCutMode) == 2'h3 && kneeReached)))
      else $error("limiter engage wrong for mode and knee");
endmodule : bvl_top_monitor

bind bvl_top bvl_top_monitor #(.CYC_PER_US(CYC_PER_US), .US_PER_MS(US_PER_MS)) mon (
   .clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
   .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
   .batteryLevel(batteryLevel), .peakCutMode(peakCutMode), .peakCutReducing(peakCutReducing),
   .kneeReached(kneeReached), .muteRequest(muteRequest), .peakCutEngage(peakCutEngage),
   .battCutDepth(battCutDepth), .peakCutTies(peakCutTies), .clipPoint(clipPoint),
   .gainCutActive(gainCutActive));

/* test/test_battery_voltage_limiter_ctrl.sv */
// self-checking bench of the battery limiter bank
module test_battery_voltage_limiter_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, resetn, regWrEn, regRdEn, regRdValid, peakCutReducing;
   logic kneeReached, muteRequest, peakCutEngage, gainCutActive;
   logic [7:0] regAddr, regWrData, regRdData, batteryLevel, clipPoint, r, e;
   logic [1:0] peakCutMode;
   logic [4:0] battCutDepth;
   logic [3:0] peakCutTies;
   logic [7:0] expQ[$];
   logic [7:0] ofs[8] = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11};
   logic [7:0] rstV[8] = '{8'h22, 8'hA0, 8'h22, 8'h65, 8'h00, 8'hFF, 8'h00, 8'h00};
   logic [7:0] oneV[8] = '{8'hFF, 8'hF0, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'h00, 8'h00};
   int errors, check_count;

   // times scaled so that one ms is one cycle
   bvl_top #(.CYC_PER_US(1), .US_PER_MS(1)) dut (.clk_sys(clk_sys), .resetn(resetn),
      .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regRdData(regRdData), .regRdValid(regRdValid), .batteryLevel(batteryLevel),
      .peakCutMode(peakCutMode), .peakCutReducing(peakCutReducing), .kneeReached(kneeReached),
      .muteRequest(muteRequest), .peakCutEngage(peakCutEngage), .battCutDepth(battCutDepth),
      .peakCutTies(peakCutTies), .clipPoint(clipPoint), .gainCutActive(gainCutActive));

   // ****************************************
   // tasks
   // ****************************************
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge clk_sys);
      regWrEn = 1'b0;
   endtask : wr

   // read strobe; the expected byte is noted for the watcher
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      @(negedge clk_sys);
      regAddr = a;
      regRdEn = 1'b1;
      expQ.push_back(x);
      @(negedge clk_sys);
      regRdEn = 1'b0;
   endtask : rd

   task automatic dwait(input int n, input logic [4:0] d);
      repeat (n) @(negedge clk_sys);
      check("cut depth", 8'(battCutDepth), 8'(d));
   endtask : dwait

   task automatic give_verdict;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict

   // ****************************************
   // clock, watchdog and read watcher
   // ****************************************
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   initial begin
      #200000;
      errors++;
      give_verdict();
   end

   // each read answer is compared with the oldest note
   always @(negedge clk_sys) begin
      if (regRdValid === 1'b1) begin
         check("read data", regRdData, (expQ.size() > 0) ? expQ.pop_front() : 8'hXX);
      end
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      resetn = 1'b0;
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      batteryLevel = 8'hC0;
      peakCutMode = 2'h0;
      peakCutReducing = 1'b0;
      void'($urandom(13258));
      repeat (2) @(negedge clk_sys);
      resetn = 1'b1;
      // reset values, then all-ones writes (FE to the rates byte) incl. reserved, status and unmapped places
      for (int i = 0; i < 8; i++) begin
         rd(ofs[i], rstV[i]);
      end
      for (int i = 0; i < 8; i++) wr(ofs[i], (ofs[i] == 8'h0B) ? 8'hFE : 8'hFF);
      for (int i = 0; i < 8; i++) begin
         rd(ofs[i], oneV[i]);
      end
      // random bytes through the full-width registers other than the clip byte
      for (int i = 0; i < 8; i++) begin
         r = 8'($urandom);
         if (ofs[i] != 8'h0B && ofs[i] < 8'h0E) begin
            wr(ofs[i], r);
            rd(ofs[i], r);
         end
      end
      // clip point byte reaches its output
      r = 8'($urandom);
      wr(8'h0F, r);
      rd(8'h0F, r); // clip byte read back
      check("clip point", clipPoint, r); // clip byte output
      // each tie bit alone, upper bits written as ones
      for (int i = 0; i < 4; i++) begin
         e = 8'h01 << i;
         wr(8'h0E, 8'hF0 | e);
         rd(8'h0E, e);
         check("tie bits", {4'h0, peakCutTies}, e);
      end
      // every mode, battery at the knee and one code above it
      wr(8'h0A, 8'h80);
      for (int m = 0; m < 4; m++) begin
         for (int b = 0; b < 2; b++) begin
            @(negedge clk_sys);
            peakCutMode = 2'(m);
            batteryLevel = (b == 1) ? 8'h80 : 8'h81;
            e = {5'h00, b[0], m == 2 && b == 1, m == 1 || (m == 3 && b == 1)};
            repeat (2) @(negedge clk_sys);
            check("mode outs", {5'h00, kneeReached, muteRequest, peakCutEngage}, e);
         end
      end
      peakCutMode = 2'h0;
      batteryLevel = 8'hC0;
      // outside gain cut shows in the status byte
      peakCutReducing = 1'b1;
      rd(8'h11, 8'h20);
      peakCutReducing = 1'b0;
      rd(8'h11, 8'h00);
      // cut: attack 15 cycles a step, cap 2 steps, hold 200, release 600 a step
      wr(8'h0C, 8'h80);
      wr(8'h0D, 8'h11);
      wr(8'h0B, 8'hF1);
      @(negedge clk_sys);
      batteryLevel = 8'h80;
      dwait(16, 5'h00);
      dwait(1, 5'h01);
      dwait(14, 5'h01);
      dwait(1, 5'h02);
      dwait(40, 5'h02);
      rd(8'h11, 8'h20);
      batteryLevel = 8'h81;
      dwait(700, 5'h02);
      dwait(150, 5'h01);
      dwait(650, 5'h00);
      // cut in progress, then enable cleared
      batteryLevel = 8'h80;
      dwait(40, 5'h02);
      wr(8'h0B, 8'hF0);
      dwait(50, 5'h00);
      check("gain flag", {7'h00, gainCutActive}, 8'h00);
      // reset rate codes, one-step cap, no hold-off: attack 22, release 900 a step
      batteryLevel = 8'h81;
      wr(8'h0D, 8'h00);
      wr(8'h0B, 8'hA1);
      batteryLevel = 8'h80;
      dwait(23, 5'h00);
      dwait(1, 5'h01);
      batteryLevel = 8'h81;
      dwait(900, 5'h01);
      dwait(5, 5'h00);
      // every read strobe has been answered
      check("reads left", 8'(expQ.size()), 8'h00);
      give_verdict();
   end
endmodule : test_battery_voltage_limiter_ctrl
